// >>> lfl_pkg.sv
// constants for the light threshold flag logic
// assumes a 16-bit configuration register image and a
// converter that pulses once per finished conversion
// Operation
// - conversion end sets done flag, bit 7
// - read or non-shutdown write clears done flag
// - above-high for fault count sets bit 6
// - below-low for fault count sets below flag
// - latch bit 0: flags and pin track comparison
// - latch bit 1: hold until config read
// - polarity 0: pin driven low when active
// - polarity 1: pin released when active
// - mask exponent when enabled and range manual
// - limit comparisons use unmasked exponent
// - fault count codes select 1,2,4,8
// - mode encoding; single-shot returns to shutdown
// - entering shutdown keeps flags and pin
// - range number below 12 means manual range
// - compare result and limits in lux scale
package lfl_pkg;
    // ------------------------------------------------
    // configuration register field positions
    // ------------------------------------------------
    localparam int unsigned RN_HI = 15;
    localparam int unsigned RN_LO = 12;
    localparam int unsigned CT_BIT = 11;
    localparam int unsigned MODE_HI = 10;
    localparam int unsigned MODE_LO = 9;
    localparam int unsigned OVF_BIT = 8;
    localparam int unsigned DONE_BIT = 7;
    localparam int unsigned ABOVE_BIT = 6;
    localparam int unsigned BELOW_BIT = 5;
    localparam int unsigned LATCH_BIT = 4;
    localparam int unsigned POL_BIT = 3;
    localparam int unsigned ME_BIT = 2;
    localparam int unsigned FC_HI = 1;
    localparam int unsigned FC_LO = 0;
    // result and limit word layout
    localparam int unsigned EXP_HI = 15;
    localparam int unsigned EXP_LO = 12;
    localparam int unsigned MANT_HI = 11;
    // ------------------------------------------------
    // reset values and codes
    // ------------------------------------------------
    localparam logic [3:0] RN_RESET = 4'hc;
    localparam logic RST_CT = 1'b1;
    localparam logic RST_LATCH = 1'b1;
    localparam logic RST_POL = 1'b0;
    localparam logic RST_ME = 1'b0;
    localparam logic [1:0] RST_FC = 2'h0;
    localparam logic [3:0] RN_AUTO_MIN = 4'hc;
    localparam logic [3:0] EXP_MASKED = 4'h0;
    localparam logic [1:0] MODE_SHUTDOWN = 2'h0;
    localparam logic [1:0] MODE_SINGLE = 2'h1;
    localparam int unsigned LUX_W = 28;
    localparam int unsigned CNT_W = 4;
    typedef logic [15:0] lfl_word_t;
endpackage

// >>> lfl_flag_logic.sv
// status and threshold reporting of the light sensor
// configuration register, with its interrupt pin
// assumes the serial interface gives one-cycle read and
// write strobes, all inputs but reset_n synchronous to core_clk
`timescale 1ns/100ps
module lfl_flag_logic
(
    // clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // configuration register access from serial port
    input wire logic cfg_wr_stb,
    input wire lfl_pkg::lfl_word_t cfg_wr_data,
    input wire logic cfg_rd_stb,
    output lfl_pkg::lfl_word_t cfg_rd_data,
    // limit registers held elsewhere
    input wire lfl_pkg::lfl_word_t low_limit,
    input wire lfl_pkg::lfl_word_t high_limit,
    // converter side
    input wire logic conv_done,
    input wire lfl_pkg::lfl_word_t conv_result,
    output logic [1:0] conv_mode,
    output lfl_pkg::lfl_word_t result_report,
    // open-drain interrupt pin
    output logic int_pin_out,
    output logic int_pin_oe_n
);
    import lfl_pkg::*;

    // ------------------------------------------------
    // reset release
    // ------------------------------------------------
    logic rst_meta; // first stage, read only by rst_n
    logic rst_n; // synchronised reset used below

    // assert at once, release after two edges
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // ------------------------------------------------
    // control fields
    // ------------------------------------------------
    logic [3:0] range_number; // full-scale range choice
    logic conv_time; // stored only, no output port, shown in read data
    logic latch_sel; // 1 = latched window style
    logic irq_polarity; // 0 = active low
    logic exponent_mask_enable; // zero reported exponent
    logic [1:0] fault_count_select; // consecutive count

    // status flags
    logic conversion_done_flag;
    logic above_limit_flag;
    logic below_limit_flag;
    logic int_active; // logical interrupt state

    // a conversion only counts while not shut down
    logic conv_take;
    assign conv_take = conv_done && (conv_mode != MODE_SHUTDOWN);

    // software-owned fields, plain storage
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            range_number <= RN_RESET;
            conv_time <= RST_CT;
            latch_sel <= RST_LATCH;
            irq_polarity <= RST_POL;
            exponent_mask_enable <= RST_ME;
            fault_count_select <= RST_FC;
        end
        else if (cfg_wr_stb)
        begin
            range_number <= cfg_wr_data[RN_HI:RN_LO];
            conv_time <= cfg_wr_data[CT_BIT];
            latch_sel <= cfg_wr_data[LATCH_BIT];
            irq_polarity <= cfg_wr_data[POL_BIT];
            exponent_mask_enable <= cfg_wr_data[ME_BIT];
            fault_count_select <= cfg_wr_data[FC_HI:FC_LO];
        end
    end

    // mode field; a write in the finishing cycle wins
    // because it states the newer wish of software
    // kept in the converter's own port register, so the
    // converter and the register image never disagree
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            conv_mode <= MODE_SHUTDOWN;
        end
        else if (cfg_wr_stb)
        begin
            conv_mode <= cfg_wr_data[MODE_HI:MODE_LO];
        end
        else if (conv_take && conv_mode == MODE_SINGLE)
        begin
            conv_mode <= MODE_SHUTDOWN;
        end
    end

    // ------------------------------------------------
    // lux scale comparison
    // ------------------------------------------------
    logic [LUX_W-1:0] res_lux; // mantissa shifted by exp
    logic [LUX_W-1:0] high_lux;
    logic [LUX_W-1:0] low_lux;
    logic is_above; // raw, unmasked exponent used
    logic is_below;

    // widen then shift; exponent up to 15 fits 28 bits
    assign res_lux = LUX_W'(conv_result[MANT_HI:0])
        << conv_result[EXP_HI:EXP_LO];
    assign high_lux = LUX_W'(high_limit[MANT_HI:0])
        << high_limit[EXP_HI:EXP_LO];
    assign low_lux = LUX_W'(low_limit[MANT_HI:0])
        << low_limit[EXP_HI:EXP_LO];
    assign is_above = res_lux > high_lux;
    assign is_below = res_lux < low_lux;

    // ------------------------------------------------
    // consecutive fault counters
    // ------------------------------------------------
    logic [CNT_W-1:0] need; // 1, 2, 4 or 8
    logic [CNT_W-1:0] high_cnt;
    logic [CNT_W-1:0] low_cnt;
    logic [CNT_W-1:0] next_high_cnt;
    logic [CNT_W-1:0] next_low_cnt;
    logic hit_high; // fault count reached this result
    logic hit_low;

    assign need = CNT_W'(1) << fault_count_select;

    // counts saturate at the target so a long run of
    // faults keeps reporting rather than wrapping
    always_comb
    begin
        next_high_cnt = '0;
        next_low_cnt = '0;
        if (is_above)
        begin
            next_high_cnt = (high_cnt >= need) ? need
                : high_cnt + CNT_W'(1);
        end
        if (is_below)
        begin
            next_low_cnt = (low_cnt >= need) ? need
                : low_cnt + CNT_W'(1);
        end
    end

    assign hit_high = is_above && (next_high_cnt >= need);
    assign hit_low = is_below && (next_low_cnt >= need);

    // counters move only on accepted conversions
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            high_cnt <= '0;
            low_cnt <= '0;
        end
        else if (conv_take)
        begin
            high_cnt <= next_high_cnt;
            low_cnt <= next_low_cnt;
        end
    end

    // ------------------------------------------------
    // conversion done flag
    // ------------------------------------------------
    logic done_clear; // read, or non-shutdown write

    assign done_clear = cfg_rd_stb || (cfg_wr_stb
        && cfg_wr_data[MODE_HI:MODE_LO] != MODE_SHUTDOWN);

    // set beats clear so no conversion end is lost
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            conversion_done_flag <= 1'b0;
        end
        else if (conv_take)
        begin
            conversion_done_flag <= 1'b1;
        end
        else if (done_clear)
        begin
            conversion_done_flag <= 1'b0;
        end
    end

    // ------------------------------------------------
    // limit flags and interrupt state
    // ------------------------------------------------
    // flags change only on conversions or reads, never
    // on a mode change, so shutdown preserves them
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            above_limit_flag <= 1'b0;
            below_limit_flag <= 1'b0;
            int_active <= 1'b0;
        end
        else if (latch_sel)
        begin
            // latched window: any hit sets, read clears;
            // a hit in the read cycle still lands
            if (conv_take && hit_high)
            begin
                above_limit_flag <= 1'b1;
            end
            else if (cfg_rd_stb)
            begin
                above_limit_flag <= 1'b0;
            end
            if (conv_take && hit_low)
            begin
                below_limit_flag <= 1'b1;
            end
            else if (cfg_rd_stb)
            begin
                below_limit_flag <= 1'b0;
            end
            if (conv_take && (hit_high || hit_low))
            begin
                int_active <= 1'b1;
            end
            else if (cfg_rd_stb)
            begin
                int_active <= 1'b0;
            end
        end
        else if (conv_take)
        begin
            // transparent hysteresis: high run sets, low
            // run clears, pin follows the high flag
            if (hit_high)
            begin
                above_limit_flag <= 1'b1;
                below_limit_flag <= 1'b0;
                int_active <= 1'b1;
            end
            else if (hit_low)
            begin
                above_limit_flag <= 1'b0;
                below_limit_flag <= 1'b1;
                int_active <= 1'b0;
            end
        end
    end

    // ------------------------------------------------
    // interrupt pin
    // ------------------------------------------------
    // pin only ever drives low; polarity decides whether
    // active means driving or releasing
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            int_pin_out <= 1'b0;
            int_pin_oe_n <= 1'b1;
        end
        else
        begin
            int_pin_out <= 1'b0;
            // pol 0: drive when active; pol 1: release
            int_pin_oe_n <= int_active ~^ irq_polarity;
        end
    end

    // ------------------------------------------------
    // reported result and register image
    // ------------------------------------------------
    logic mask_now; // manual range with masking on

    assign mask_now = exponent_mask_enable
        && (range_number < RN_AUTO_MIN);

    // masked copy only; comparisons used conv_result
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            result_report <= '0;
        end
        else if (conv_take)
        begin
            result_report[MANT_HI:0] <= conv_result[MANT_HI:0];
            result_report[EXP_HI:EXP_LO] <= mask_now ? EXP_MASKED
                : conv_result[EXP_HI:EXP_LO];
        end
    end

    // read data shows state before the read's clearing
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cfg_rd_data <= '0;
        end
        else if (cfg_rd_stb)
        begin
            cfg_rd_data[RN_HI:RN_LO] <= range_number;
            cfg_rd_data[CT_BIT] <= conv_time;
            cfg_rd_data[MODE_HI:MODE_LO] <= conv_mode;
            cfg_rd_data[OVF_BIT] <= 1'b0;
            cfg_rd_data[DONE_BIT] <= conversion_done_flag;
            cfg_rd_data[ABOVE_BIT] <= above_limit_flag;
            cfg_rd_data[BELOW_BIT] <= below_limit_flag;
            cfg_rd_data[LATCH_BIT] <= latch_sel;
            cfg_rd_data[POL_BIT] <= irq_polarity;
            cfg_rd_data[ME_BIT] <= exponent_mask_enable;
            cfg_rd_data[FC_HI:FC_LO] <= fault_count_select;
        end
    end
endmodule // lfl_flag_logic

// >>> lfl_flag_sva.sv
// port checker for the light threshold flag logic
// assumes one clock domain, core_clk, reset_n async low
`timescale 1ns/100ps
module lfl_flag_sva
(
    // clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // register access
    input wire logic cfg_wr_stb,
    input wire lfl_pkg::lfl_word_t cfg_wr_data,
    input wire logic cfg_rd_stb,
    input wire lfl_pkg::lfl_word_t cfg_rd_data,
    // converter and pin
    input wire logic conv_done,
    input wire lfl_pkg::lfl_word_t conv_result,
    input wire logic [1:0] conv_mode,
    input wire lfl_pkg::lfl_word_t result_report,
    input wire logic int_pin_out
);
    import lfl_pkg::*;
    // ----------------------------------------
    // common clocking
    // ----------------------------------------
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    // conversion accepted only outside shutdown
    wire logic conv_taken = conv_done && conv_mode != MODE_SHUTDOWN;
    AST_DONE_SET: assert property (
        conv_taken ##1 (!cfg_rd_stb && !cfg_wr_stb) [*2] ##1 cfg_rd_stb
        |=> cfg_rd_data[DONE_BIT])
        else $error("done flag not set after conversion");
    AST_DONE_CLR: assert property (
        cfg_rd_stb && !conv_done ##1 (!conv_done && !cfg_rd_stb) [*2]
        ##1 cfg_rd_stb |=> !cfg_rd_data[DONE_BIT])
        else $error("done flag survived a read");
    AST_SINGLE_END: assert property (
        conv_done && conv_mode == MODE_SINGLE && !cfg_wr_stb
        |=> conv_mode == MODE_SHUTDOWN)
        else $error("single shot did not return to shutdown");
    AST_SHUT_KEEP: assert property (
        conv_mode == MODE_SHUTDOWN && !cfg_wr_stb
        |=> conv_mode == MODE_SHUTDOWN && $stable(result_report))
        else $error("shutdown state disturbed");
    AST_MASK: assert property (
        conv_taken |=> result_report[MANT_HI:0]
        == $past(conv_result[MANT_HI:0])
        && (result_report[EXP_HI:EXP_LO]
        == $past(conv_result[EXP_HI:EXP_LO])
        || result_report[EXP_HI:EXP_LO] == EXP_MASKED))
        else $error("reported result corrupted");
    AST_MODE_WR: assert property (
        cfg_wr_stb |=> conv_mode == $past(cfg_wr_data[MODE_HI:MODE_LO]))
        else $error("written mode not taken");
    AST_FIELDS: assert property (
        cfg_wr_stb ##1 !cfg_wr_stb [*2] ##1 cfg_rd_stb
        |=> cfg_rd_data[LATCH_BIT:FC_LO] == $past(cfg_wr_data[4:0], 4))
        else $error("control fields not read back");
    AST_RD_HOLD: assert property (
        !cfg_rd_stb |=> $stable(cfg_rd_data))
        else $error("read data moved without a read");
    AST_PIN_LOW: assert property (
        int_pin_out == 1'b0)
        else $error("open drain pin drove high");
    // main scenarios reached
    cover property (conv_done && conv_mode == MODE_SINGLE);
    cover property (cfg_rd_stb ##1 cfg_rd_data[ABOVE_BIT]);
    cover property (conv_taken ##1 result_report[EXP_HI:EXP_LO] == EXP_MASKED);
endmodule // lfl_flag_sva
bind lfl_flag_logic lfl_flag_sva lfl_flag_sva_inst (.core_clk(core_clk),
    .reset_n(reset_n), .cfg_wr_stb(cfg_wr_stb), .cfg_wr_data(cfg_wr_data),
    .cfg_rd_stb(cfg_rd_stb), .cfg_rd_data(cfg_rd_data),
    .conv_done(conv_done), .conv_result(conv_result),
    .conv_mode(conv_mode), .result_report(result_report),
    .int_pin_out(int_pin_out));

// >>> lfl_conv_model.sv
// converter stand-in and interrupt pull-up for the bench
// assumes requests arrive by non-blocking assignment
`timescale 1ns/100ps
module lfl_conv_model
(
    // clock
    input wire logic core_clk,
    // request from bench
    input wire logic go,
    input wire lfl_pkg::lfl_word_t val,
    // converter outputs
    output logic conv_done = 1'b0,
    output lfl_pkg::lfl_word_t conv_result = 16'h5a5a,
    // open-drain pin and resolved wire
    input wire logic int_pin_out,
    input wire logic int_pin_oe_n,
    output logic int_wire
);
    import lfl_pkg::*;
    // one-cycle pulse; result scrambled outside it so
    // a late sample never sees a stale value
    always @(negedge core_clk)
    begin
        conv_done <= go;
        conv_result <= go ? val : ~conv_result;
    end
    // pull-up wins while the pin is released
    assign int_wire = int_pin_oe_n ? 1'b1 : int_pin_out;
endmodule // lfl_conv_model

// >>> lfl_flag_logic_tb.sv
// bench for the flag logic against an integer model
// assumes lfl_conv_model stands in for the converter
`timescale 1ns/100ps
module lfl_flag_logic_tb;
    import lfl_pkg::*;
    logic core_clk = 0, reset_n = 0, wr = 0, rd = 0, go = 0;
    lfl_word_t wd = 0, lo = 16'h0080, hi = 16'h2100, val = 0;
    lfl_word_t res, rdd, rep_o;
    logic cd, ipo, ioe, iw;
    logic [1:0] mode_o;
    logic [15:0] lf = 16'h0023;
    int miscompares = 0, check_count = 0, cyc = 0;
    // model state: config image, flags, counters
    int cfg = 'hc810, dn, fh, fl, ia, ch, cl, rep;
    always #5 core_clk = ~core_clk;
    lfl_flag_logic lfl_flag_logic_inst (.core_clk(core_clk),
        .reset_n(reset_n), .cfg_wr_stb(wr), .cfg_wr_data(wd),
        .cfg_rd_stb(rd), .cfg_rd_data(rdd), .low_limit(lo),
        .high_limit(hi), .conv_done(cd), .conv_result(res),
        .conv_mode(mode_o), .result_report(rep_o),
        .int_pin_out(ipo), .int_pin_oe_n(ioe));
    lfl_conv_model lfl_conv_model_inst (.core_clk(core_clk), .go(go),
        .val(val), .conv_done(cd), .conv_result(res),
        .int_pin_out(ipo), .int_pin_oe_n(ioe), .int_wire(iw));
    // hang guard, far above the few hundred cycles used
    always @(posedge core_clk)
        if (++cyc == 3000)
        begin
            miscompares++;
            end_of_test();
        end
    function automatic int lux(int w);
        return (w & 'hfff) << (w >> 12 & 'hf);
    endfunction
    function automatic int rnd(int base, int m);
        lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
        return base + (lf & m);
    endfunction
    task automatic chk_word(string n, int e, lfl_word_t s);
        check_count++;
        if (s !== e[15:0])
        begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", n, e[15:0], s);
        end
    endtask
    task automatic chk_bit(string n, int e, logic s);
        check_count++;
        if (s !== e[0])
        begin
            miscompares++;
            $display("wrong value %s expected %b seen %b", n, e[0], s);
        end
    endtask
    task automatic pin_chk();
        @(negedge core_clk);
        chk_bit("int pin", !(ia ^ (cfg >> 3 & 1)), iw);
    endtask
    task automatic cfg_write(int d);
        @(negedge core_clk);
        wd = d[15:0];
        wr = 1;
        @(negedge core_clk);
        wr = 0;
        cfg = d & 'hfe1f;
        if ((d >> 9 & 3) != 0)
            dn = 0;
        pin_chk();
    endtask
    task automatic cfg_read();
        @(negedge core_clk);
        rd = 1;
        @(negedge core_clk);
        rd = 0;
        chk_word("config", cfg | dn << 7 | fh << 6 | fl << 5, rdd);
        dn = 0;
        if (cfg >> 4 & 1)
        begin
            fh = 0;
            fl = 0;
            ia = 0;
        end
        pin_chk();
    endtask
    task automatic conv(int r);
        int t;
        @(negedge core_clk);
        go <= 1;
        val <= r[15:0];
        @(negedge core_clk);
        go <= 0;
        @(negedge core_clk);
        t = 1 << (cfg & 3);
        if ((cfg >> 9 & 3) != 0)
        begin
            ch = lux(r) > lux(hi) ? (ch < t ? ch + 1 : t) : 0;
            cl = lux(r) < lux(lo) ? (cl < t ? cl + 1 : t) : 0;
            if (cfg >> 4 & 1)
            begin
                fh = fh | ch >= t;
                fl = fl | cl >= t;
                ia = ia | ch >= t | cl >= t;
            end
            else if (ch >= t || cl >= t)
            begin
                fh = ch >= t;
                fl = !fh;
                ia = fh;
            end
            dn = 1;
            rep = (cfg >> 2 & 1) && (cfg >> 12) < 12 ? r & 'hfff : r;
            if ((cfg >> 9 & 3) == 1)
                cfg = cfg & 'hf9ff;
        end
        chk_word("report", rep, rep_o);
        chk_word("mode", cfg >> 9 & 3, {14'h0, mode_o});
        pin_chk();
    endtask
    task automatic test_end(string n);
        $display("test %s finished", n);
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        repeat (3) @(negedge core_clk);
        reset_n = 1;
        repeat (3) @(negedge core_clk);
        cfg_read();
        test_end("reset");
        conv(rnd('h5800, 'h7ff));
        cfg_write('hca10);
        conv(rnd('h5800, 'h7ff));
        conv(rnd(0, 'h7f));
        cfg_write('hc810);
        cfg_read();
        cfg_read();
        test_end("single shot");
        for (int f = 0; f < 4; f++)
        begin
            cfg_write('hcc10 | f);
            cfg_read();
            repeat ((1 << f) - 1) conv(rnd('h5800, 'h7ff));
            conv(rnd('h10c0, 'h3f));
            repeat (1 << f) conv(rnd('h5800, 'h7ff));
            cfg_read();
            repeat (1 << f) conv(rnd(0, 'h7f));
            cfg_read();
        end
        test_end("fault count");
        for (int p = 0; p < 2; p++)
        begin
            cfg_write('hcc00 | p << 3);
            conv(rnd(0, 'h7f));
            cfg_read();
            conv(rnd('h10c0, 'h3f));
            conv('h3080);
            conv(rnd('h5800, 'h7ff));
            cfg_read();
        end
        test_end("transparent");
        // manual range, continuous mode code 11; the result
        // is above the high limit only with its exponent,
        // so a masked compare would flip it to below
        cfg_write('h5e04);
        conv('h407f);
        cfg_read();
        cfg_write('hcc04);
        conv('h3100);
        test_end("mask");
        end_of_test();
    end
endmodule // lfl_flag_logic_tb
